// ==== plac_pkg.sv ====
package plac_pkg;
  // ***********************************
  // widths
  // ***********************************
  localparam int PORT_W = 8;
  localparam int AXI_AW = 32;
  localparam int AXI_DW = 32;
  // ***********************************
  // register byte offsets
  // ***********************************
  localparam logic [AXI_AW-1:0] OFS_LATCH = 32'h00000000;
  localparam logic [AXI_AW-1:0] OFS_DIRECTION = 32'h00000004;
  localparam logic [AXI_AW-1:0] OFS_INBUF = 32'h00000008;
  localparam logic [AXI_AW-1:0] OFS_ODRIVE = 32'h0000000c;
  localparam logic [AXI_AW-1:0] OFS_ANALOG = 32'h00000010;
  localparam logic [AXI_AW-1:0] OFS_REDIRECT = 32'h00000014;
  localparam logic [AXI_AW-1:0] OFS_RMW = 32'h00000018;
  localparam logic [AXI_AW-1:0] OFS_PINRAW = 32'h0000001c;
  // ***********************************
  // reset values
  // ***********************************
  localparam logic [PORT_W-1:0] RST_LATCH = 8'h00;
  localparam logic [PORT_W-1:0] RST_DIRECTION = 8'hff;
  localparam logic [PORT_W-1:0] RST_INBUF = 8'h00;
  localparam logic [PORT_W-1:0] RST_ODRIVE = 8'h00;
  localparam logic [PORT_W-1:0] RST_ANALOG = 8'hff;
  localparam logic [PORT_W-1:0] RST_REDIRECT = 8'h00;
  // ***********************************
  // fields and pin positions
  // ***********************************
  localparam int SERIAL_REDIRECT_POS = 1;
  localparam int RX_DEF_BIT = 0;
  localparam int RX_RELOC_BIT = 6;
  localparam int TX_DEF_BIT = 1;
  localparam int TX_RELOC_BIT = 7;
  localparam int RMW_OP_LSB = 8;
  localparam logic [1:0] RMW_AND = 2'h0;
  localparam logic [1:0] RMW_OR = 2'h1;
  localparam logic [1:0] RMW_XOR = 2'h2;
  localparam logic [1:0] RMW_MOVE = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {WR_COLLECT, WR_RESP} plac_wr_t;
endpackage : plac_pkg

// ==== plac_sync.sv ====
`timescale 1ns/1ps
module plac_sync #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_syncOut;

  // first stage feeds only the second
  always_comb begin
    next_stage1 = asyncIn;
    next_syncOut = stage1;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= '0;
      syncOut <= '0;
    end else begin
      stage1 <= next_stage1;
      syncOut <= next_syncOut;
    end
  end
endmodule : plac_sync

// ==== plac_port.sv ====
// Notes on behaviour
// R1: output mode writes latch, latch drives pin
// R2: latch keeps value until next write
// R3: reset clears every latch bit
// R4: input mode write updates latch, driver off
// R5: output bit reads return latch value
// R6: input bit reads return pin level
// R7: reads never modify the latch
// R8: output bit operations use latch operand
// R9: input bit operations use pin operand
// R10: per-bit one selects ttl input buffer
// R11: open-drain bit leaves high latch undriven
// R12: after reset all pins input, undriven
// R13: software sets latch, open-drain, then output
// R14: open-drain output still passes pin input
// R15: software sets direction and latch per function
// R16: software parks unused alternate outputs idle
// R17: redirect bit moves serial pins elsewhere
// R18: analog bit one selects analog path
// R19: analog bits reset to one
// R20: pin input synchronised before use
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module plac_port (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [plac_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [plac_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [plac_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [plac_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [plac_pkg::PORT_W-1:0] pinIn,
  output logic [plac_pkg::PORT_W-1:0] pinOut,
  output logic [plac_pkg::PORT_W-1:0] pinOe,
  output logic [plac_pkg::PORT_W-1:0] ttlSel,
  output logic [plac_pkg::PORT_W-1:0] analogSel,
  output logic [plac_pkg::PORT_W-1:0] serialDataIn,
  output logic asyncRxInput,
  input wire logic asyncTxOutput
);
  import plac_pkg::*;

  // ***********************************
  // state
  // ***********************************
  plac_wr_t wrState;
  plac_wr_t next_wrState;
  logic awGot, next_awGot;
  logic wGot, next_wGot;
  logic [AXI_AW-1:0] awAddr, next_awAddr;
  logic [AXI_DW-1:0] wData, next_wData;
  logic [3:0] wStrb, next_wStrb;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [AXI_DW-1:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic [PORT_W-1:0] latch, next_latch;
  logic [PORT_W-1:0] direction, next_direction;
  logic [PORT_W-1:0] inBuf, next_inBuf;
  logic [PORT_W-1:0] oDrive, next_oDrive;
  logic [PORT_W-1:0] analog, next_analog;
  logic [PORT_W-1:0] redirect, next_redirect;
  logic [PORT_W-1:0] pinOutQ, next_pinOut;
  logic [PORT_W-1:0] pinOeQ, next_pinOe;
  logic [PORT_W-1:0] pinSync;
  logic [PORT_W-1:0] readPort;
  logic [PORT_W-1:0] rmwResult;
  logic [PORT_W-1:0] pinData;
  logic doWrite;
  logic wrHit;
  logic arHit;
  logic serialRedirect;

  // ***********************************
  // pin input synchroniser
  // ***********************************
  plac_sync #(.W(PORT_W)) u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .asyncIn(pinIn),
    .syncOut(pinSync) // [R20]
  );

  // ***********************************
  // port datapath
  // ***********************************
  assign serialRedirect = redirect[SERIAL_REDIRECT_POS];
  // analog bits in input mode read zero on the digital side; output bits read the latch
  assign readPort = (direction & pinSync & ~analog) | (~direction & latch); // [R5] [R6] [R18]

  always_comb begin
    rmwResult = readPort; // [R8] [R9]
    unique case (wData[RMW_OP_LSB+1:RMW_OP_LSB])
      RMW_AND: rmwResult = readPort & wData[PORT_W-1:0];
      RMW_OR: rmwResult = readPort | wData[PORT_W-1:0];
      RMW_XOR: rmwResult = readPort ^ wData[PORT_W-1:0];
      RMW_MOVE: rmwResult = readPort;
    endcase
  end

  always_comb begin
    pinData = latch;
    // transmit is gated by the latch, so a latch of one lets it through
    if (serialRedirect) begin
      pinData[TX_RELOC_BIT] = latch[TX_RELOC_BIT] & asyncTxOutput; // [R17]
    end else begin
      pinData[TX_DEF_BIT] = latch[TX_DEF_BIT] & asyncTxOutput;
    end
    next_pinOut = pinData; // [R1]
    next_pinOe = ~direction & ~analog & ~(oDrive & pinData); // [R4] [R11] [R12] [R18]
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pinOutQ <= '0;
      pinOeQ <= '0;
    end else begin
      pinOutQ <= next_pinOut;
      pinOeQ <= next_pinOe;
    end
  end

  assign pinOut = pinOutQ;
  assign pinOe = pinOeQ;
  assign ttlSel = inBuf; // [R10]
  assign analogSel = analog;
  // open-drain output still hears the wire, for two-wire data
  assign serialDataIn = pinSync; // [R14]
  assign asyncRxInput = serialRedirect ? pinSync[RX_RELOC_BIT] : pinSync[RX_DEF_BIT]; // [R17]

  // ***********************************
  // axi write channel
  // ***********************************
  assign s_axi_awready = !awGot && (wrState == WR_COLLECT);
  assign s_axi_wready = !wGot && (wrState == WR_COLLECT);
  assign doWrite = awGot && wGot && (wrState == WR_COLLECT);
  assign wrHit = (awAddr[AXI_AW-1:5] == '0) && (awAddr[1:0] == 2'h0);

  always_comb begin
    next_wrState = wrState;
    next_awGot = awGot;
    next_wGot = wGot;
    next_awAddr = awAddr;
    next_wData = wData;
    next_wStrb = wStrb;
    next_bresp = bresp;
    next_latch = latch; // [R2] [R7]
    next_direction = direction;
    next_inBuf = inBuf;
    next_oDrive = oDrive;
    next_analog = analog;
    next_redirect = redirect;
    if (s_axi_awvalid && s_axi_awready) begin
      next_awGot = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wGot = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    unique case (wrState)
      WR_COLLECT: begin
        if (doWrite) begin
          next_wrState = WR_RESP;
          next_awGot = 1'b0;
          next_wGot = 1'b0;
          next_bresp = wrHit ? RESP_OKAY : RESP_SLVERR;
          if (wrHit && wStrb[0]) begin
            unique case (awAddr)
              OFS_LATCH: next_latch = wData[PORT_W-1:0]; // [R1] [R4]
              OFS_DIRECTION: next_direction = wData[PORT_W-1:0];
              OFS_INBUF: next_inBuf = wData[PORT_W-1:0];
              OFS_ODRIVE: next_oDrive = wData[PORT_W-1:0];
              OFS_ANALOG: next_analog = wData[PORT_W-1:0];
              OFS_REDIRECT: next_redirect = wData[PORT_W-1:0] & 8'h02;
              OFS_RMW: begin
                if (wStrb[1]) begin
                  next_latch = rmwResult; // [R8] [R9]
                end
              end
              default: begin
              end
            endcase
          end
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          next_wrState = WR_COLLECT;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wrState <= WR_COLLECT;
      awGot <= 1'b0;
      wGot <= 1'b0;
      awAddr <= '0;
      wData <= '0;
      wStrb <= 4'h0;
      bresp <= RESP_OKAY;
      latch <= RST_LATCH; // [R3]
      direction <= RST_DIRECTION; // [R12]
      inBuf <= RST_INBUF;
      oDrive <= RST_ODRIVE;
      analog <= RST_ANALOG; // [R19]
      redirect <= RST_REDIRECT;
    end else begin
      wrState <= next_wrState;
      awGot <= next_awGot;
      wGot <= next_wGot;
      awAddr <= next_awAddr;
      wData <= next_wData;
      wStrb <= next_wStrb;
      bresp <= next_bresp;
      latch <= next_latch;
      direction <= next_direction;
      inBuf <= next_inBuf;
      oDrive <= next_oDrive;
      analog <= next_analog;
      redirect <= next_redirect;
    end
  end

  assign s_axi_bvalid = (wrState == WR_RESP);
  assign s_axi_bresp = bresp;

  // ***********************************
  // axi read channel
  // ***********************************
  assign s_axi_arready = !rvalid;
  assign arHit = (s_axi_araddr[AXI_AW-1:5] == '0) && (s_axi_araddr[1:0] == 2'h0);

  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = arHit ? RESP_OKAY : RESP_SLVERR;
      next_rdata = '0;
      if (arHit) begin
        unique case (s_axi_araddr)
          OFS_LATCH: next_rdata[PORT_W-1:0] = readPort; // [R5] [R6] [R7]
          OFS_DIRECTION: next_rdata[PORT_W-1:0] = direction;
          OFS_INBUF: next_rdata[PORT_W-1:0] = inBuf;
          OFS_ODRIVE: next_rdata[PORT_W-1:0] = oDrive;
          OFS_ANALOG: next_rdata[PORT_W-1:0] = analog;
          OFS_REDIRECT: next_rdata[PORT_W-1:0] = redirect;
          OFS_PINRAW: next_rdata[PORT_W-1:0] = pinSync;
          default: next_rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  // ***********************************
  // checks
  // ***********************************
  a_reset_latch_clear: assert property (@(posedge sys_clk) disable iff (!resetn) // [R3] [R12]
    $rose(resetn) |-> (latch == 8'h00) && (pinOe == 8'h00))
    else $error("latch or drive not clear after reset");
  a_latch_write_value: assert property (@(posedge sys_clk) disable iff (!resetn) // [R1] [R4]
    doWrite && wrHit && wStrb[0] && (awAddr == OFS_LATCH)
    |=> latch == $past(wData[PORT_W-1:0]))
    else $error("latch write lost");
  a_latch_holds: assert property (@(posedge sys_clk) disable iff (!resetn) // [R2] [R7]
    !doWrite |=> $stable(latch))
    else $error("latch changed without write");
  a_input_undriven: assert property (@(posedge sys_clk) disable iff (!resetn) // [R4] [R12]
    direction == 8'hff |=> pinOe == 8'h00)
    else $error("input pin driven");
  a_open_drain_high: assert property (@(posedge sys_clk) disable iff (!resetn) // [R11]
    ##1 (pinOe & $past(oDrive) & pinOut) == 8'h00)
    else $error("open drain drives high");
  a_read_port_value: assert property (@(posedge sys_clk) disable iff (!resetn) // [R5] [R6] [R18]
    s_axi_arvalid && s_axi_arready && (s_axi_araddr == OFS_LATCH)
    |=> s_axi_rvalid && (s_axi_rdata[PORT_W-1:0] ==
      (($past(direction) & $past(pinSync) & ~$past(analog)) |
       (~$past(direction) & $past(latch)))))
    else $error("port read value wrong");
  a_rmw_result: assert property (@(posedge sys_clk) disable iff (!resetn) // [R8] [R9]
    doWrite && wrHit && (wStrb[1:0] == 2'h3) && (awAddr == OFS_RMW)
      && (wData[RMW_OP_LSB+1:RMW_OP_LSB] == RMW_XOR)
    |=> latch == ($past(readPort) ^ $past(wData[PORT_W-1:0])))
    else $error("operation result wrong");
  a_rx_route: assert property (@(posedge sys_clk) disable iff (!resetn) // [R17]
    serialRedirect |-> asyncRxInput == pinSync[RX_RELOC_BIT])
    else $error("receive input not relocated");
  a_sync_two_stage: assert property (@(posedge sys_clk) disable iff (!resetn) // [R20] [R14]
    resetn |-> ##2 serialDataIn == $past(pinIn, 2))
    else $error("pin sync latency wrong");
  a_write_response: assert property (@(posedge sys_clk) disable iff (!resetn) // [R1]
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_analog_undriven: assert property (@(posedge sys_clk) disable iff (!resetn) // [R18] [R19]
    ##1 (pinOe & $past(analog)) == 8'h00)
    else $error("analog pin driven");
endmodule : plac_port

// ==== plac_pin_model.sv ====
`timescale 1ns/1ps
// ***********************************
// pins seen from the board side
// ***********************************
module plac_pin_model (
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  input wire logic [7:0] extEn,
  input wire logic [7:0] extVal,
  output logic [7:0] pinLevel
);
  // external pull-ups: a released pin reads high, never unknown
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pinOe[i]) begin
        pinLevel[i] = pinOut[i];
      end else if (extEn[i]) begin
        pinLevel[i] = extVal[i];
      end else begin
        pinLevel[i] = 1'b1;
      end
    end
  end
endmodule : plac_pin_model

// ==== tb_plac_port.sv ====
`timescale 1ns/1ps
module tb_plac_port;
  import plac_pkg::*;
  logic sys_clk, resetn;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [7:0] pinLevel, pinOut, pinOe, ttlSel, analogSel, serialDataIn, extEn, extVal, lat;
  logic asyncRxInput, asyncTxOutput;
  int n_fail = 0;
  int samples_checked = 0;

  plac_port uut (.sys_clk(sys_clk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pinIn(pinLevel), .pinOut(pinOut), .pinOe(pinOe),
    .ttlSel(ttlSel), .analogSel(analogSel), .serialDataIn(serialDataIn),
    .asyncRxInput(asyncRxInput), .asyncTxOutput(asyncTxOutput));

  plac_pin_model pm (.pinOut(pinOut), .pinOe(pinOe), .extEn(extEn), .extVal(extVal),
    .pinLevel(pinLevel));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ***********************************
  // checking and closing
  // ***********************************
  task print_verdict;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task hang;
    n_fail++;
    print_verdict;
  endtask : hang

  task wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wt

  // ***********************************
  // register bus master
  // ***********************************
  task wr(input logic [31:0] a, input logic [31:0] d);
    bit done;
    done = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int k = 0; k < 40 && !done; k++) begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1;
      end
    end
    if (!done) hang;
  endtask : wr

  task rdr(input logic [31:0] a);
    bit done;
    done = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int k = 0; k < 40 && !done; k++) begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1;
      end
    end
    if (!done) hang;
  endtask : rdr

  task rc(input logic [31:0] a, input logic [31:0] exp);
    rdr(a);
    chk(rd, exp);
  endtask : rc

  function automatic logic [7:0] op(input logic [1:0] c, input logic [7:0] a, input logic [7:0] b);
    case (c)
      RMW_AND: op = a & b;
      RMW_OR: op = a | b;
      RMW_XOR: op = a ^ b;
      default: op = a;
    endcase
  endfunction : op

  // ***********************************
  // main sequence
  // ***********************************
  initial begin
    resetn = 1'b0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    extEn = 8'h00;
    extVal = 8'h00;
    asyncTxOutput = 1'b1;
    wt(2);
    resetn <= 1'b1;
    wt(1);
    chk(pinOe, 32'h0);
    rc(OFS_LATCH, 32'h0);
    rc(OFS_DIRECTION, 32'hff);
    rc(OFS_INBUF, 32'h0);
    rc(OFS_ODRIVE, 32'h0);
    rc(OFS_ANALOG, 32'hff);
    wr(OFS_ANALOG, 32'h0);
    extEn <= 8'hff;
    extVal <= 8'h5a;
    wr(OFS_LATCH, 32'ha5);
    wt(2);
    chk(pinOe, 32'h0);
    rc(OFS_LATCH, 32'h5a);
    rc(OFS_PINRAW, 32'h5a);
    extEn <= 8'hf0;
    wr(OFS_DIRECTION, 32'hf0);
    wt(2);
    chk(pinOe, 32'h0f);
    chk(pinOut[3:0], 32'h5);
    rc(OFS_LATCH, 32'h55);
    chk(pinOut[3:0], 32'h5);
    // operand of each bit: pin level above, latch below
    lat = 8'ha5;
    for (int i = 0; i < 4; i++) begin
      lat = op(i[1:0], {4'h5, lat[3:0]}, 8'h3c);
      wr(OFS_RMW, {22'h0, i[1:0], 8'h3c});
      wt(2);
      chk(pinOut[3:0], lat[3:0]);
      rc(OFS_LATCH, {24'h0, 4'h5, lat[3:0]});
    end
    extEn <= 8'h00;
    wr(OFS_DIRECTION, 32'h0);
    wt(2);
    chk(pinOut, lat);
    chk(pinOe, 32'hff);
    // open-drain bring-up: latch high, drain type, then output
    wr(OFS_DIRECTION, 32'hff);
    wr(OFS_LATCH, 32'hff);
    wr(OFS_ODRIVE, 32'h01);
    wr(OFS_DIRECTION, 32'h40);
    wt(2);
    chk(pinOe[0], 32'h0);
    chk(pinLevel[0], 32'h1);
    extEn <= 8'h41;
    extVal <= 8'h00;
    wt(3);
    chk(serialDataIn[0], 32'h0);
    chk(asyncRxInput, 32'h0);
    extEn <= 8'h40;
    wr(OFS_LATCH, 32'hfe);
    wt(2);
    chk(pinOe[0], 32'h1);
    chk(pinOut[0], 32'h0);
    wr(OFS_REDIRECT, 32'h02);
    rc(OFS_REDIRECT, 32'h02);
    wt(3);
    chk(asyncRxInput, 32'h0);
    extVal <= 8'h40;
    wt(3);
    chk(asyncRxInput, 32'h1);
    asyncTxOutput <= 1'b0;
    wt(3);
    chk(pinOut[7], 32'h0);
    asyncTxOutput <= 1'b1;
    wr(OFS_ANALOG, 32'h04);
    wt(2);
    chk(analogSel, 32'h04);
    chk(pinOe[2], 32'h0);
    wr(OFS_INBUF, 32'h81);
    chk(ttlSel, 32'h81);
    wr(32'h20, 32'hff);
    chk(resp, RESP_SLVERR);
    rc(OFS_LATCH, 32'hfe);
    chk(resp, RESP_OKAY);
    rc(32'h20, 32'h0);
    chk(resp, RESP_SLVERR);
    // second reset in mid-run
    resetn <= 1'b0;
    wt(2);
    resetn <= 1'b1;
    wt(1);
    chk(pinOe, 32'h0);
    wr(OFS_ANALOG, 32'h0);
    wr(OFS_DIRECTION, 32'h0);
    wt(2);
    chk(pinOut, 32'h0);
    print_verdict;
  end
endmodule : tb_plac_port
